// ==== shared/emdr_map.vh ====
`ifndef EMDR_MAP_VH
`define EMDR_MAP_VH
// ------------------------------------------------------------
// register offsets of the channel slice
// ------------------------------------------------------------
`define EMDR_A_CTRL      8'h24
`define EMDR_A_CNT_HI    8'h25
`define EMDR_A_CNT_LO    8'h26
`define EMDR_A_HOPEN     8'h27
`define EMDR_A_VOPEN     8'h28
`define EMDR_A_VRANGE    8'h29
`define EMDR_A_TIMER     8'h2A
`define EMDR_A_MINHIT    8'h2B
`define EMDR_A_POLICY    8'h2C
// ------------------------------------------------------------
// field positions of the control and status byte
// ------------------------------------------------------------
`define EMDR_B_FAST      7
`define EMDR_B_NOLOCK    6
`define EMDR_B_NOHITS    5
`define EMDR_B_NOVERT    4
`define EMDR_B_RSVD      3
`define EMDR_B_DFE_GO    2
`define EMDR_B_EYE_GO    1
`define EMDR_B_CNT_GO    0
// ------------------------------------------------------------
// field positions of the other bytes
// ------------------------------------------------------------
`define EMDR_B_VR_HI     6
`define EMDR_B_VR_LO     5
`define EMDR_B_SCALE     6
`define EMDR_B_QM_HI     5
`define EMDR_B_QM_LO     4
`define EMDR_B_LOOK_HI   3
`define EMDR_B_LOOK_LO   0
`define EMDR_B_MIN_HI    3
`define EMDR_B_MIN_LO    0
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define EMDR_R_CTRL      8'h00
`define EMDR_R_ZERO      8'h00
`define EMDR_R_TIMER     8'h30
`define EMDR_R_POLICY    8'h72
`define EMDR_HOPEN_MAX   8'h3F
`define EMDR_SAT         8'hFF
`define EMDR_QM_NONE     2'h0
// ------------------------------------------------------------
// bits that the configuration memory may load
// ------------------------------------------------------------
`define EMDR_EE_MINHIT   8'h3F
`define EMDR_EE_POLICY   8'h7F
`endif

// ==== logic/emdr_op.v ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// one self-clearing start bit with its launch pulse
// ------------------------------------------------------------
module emdr_op (
  input  wire mclk,
  input  wire resetn,
  input  wire launch,
  input  wire done,
  output reg  busy_q,
  output reg  go_q
);

  // ----------------------------------------------------------
  // busy bit and one-cycle launch pulse
  // ----------------------------------------------------------
  // a launch while busy is ignored; busy drops on done only
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      go_q   <= 1'b0;
    end else begin
      go_q <= launch & ~busy_q;
      if (!busy_q && launch) begin
        busy_q <= 1'b1;
      end else if (busy_q && done) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/emdr_regs.v ====
// Contract
// - bit 7 of eye_dfe_control_status selects fast eye mode
// - flags report no hits and no vertical eye
// - self-clearing adaptation start, no-lock flag at bit 6
// - self-clearing start of eye opening measurement
// - self-clearing start of eye monitor counter
// - sixteen-bit count split over eye_count_high and eye_count_low
// - horizontal opening 0-63 and vertical opening readable
// - eye_voltage_range_readback bits 6:5 echo selected voltage range
// - timer threshold at eye_timer_threshold, default 30 hex
// - minimum hit count in min_hit_count_config bits 3:0
// - adaptation_policy_config bit 6 scales vertical opening by range
// - quality metric choice from adaptation_policy_config bits 5:4
// - look-beyond count in adaptation_policy_config bits 3:0
`include "emdr_map.vh"
`timescale 1ns/1ps
`default_nettype none
module emdr_regs (
  input  wire        mclk,
  input  wire        resetn,
  // register port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  // configuration memory load port
  input  wire        cfg_ld,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_data,
  // voltage range field from the range control register
  input  wire [1:0]  eye_monitor_vrange,
  // eye monitor counter engine
  output wire        eye_monitor_start,
  input  wire        eye_monitor_done,
  input  wire [15:0] eye_monitor_count,
  // eye opening measurement engine
  output wire        opening_start,
  input  wire        opening_done,
  input  wire [7:0]  horizontal_eye_opening,
  input  wire [7:0]  vertical_eye_opening,
  input  wire        opening_no_hits,
  input  wire        opening_no_vert,
  // equalizer adaptation engine
  output wire        adapt_start,
  input  wire        adapt_done,
  input  wire        adapt_locked,
  // settings that steer the engines
  output reg         fast_mode_q,
  output reg  [7:0]  timer_threshold_q,
  output reg  [3:0]  min_hits_q,
  output reg  [1:0]  quality_metric_q,
  output reg  [3:0]  look_beyond_q
);

  // ----------------------------------------------------------
  // address decode
  // ----------------------------------------------------------
  wire wr_ctrl;    // write to control and status byte
  wire wr_vrange;  // write to range readback byte
  wire wr_timer;   // write to timer threshold
  wire wr_minhit;  // write to minimum hit byte
  wire wr_policy;  // write to adaptation policy byte
  wire ee_timer;   // memory load of timer threshold
  wire ee_minhit;  // memory load of minimum hit byte
  wire ee_policy;  // memory load of policy byte

  assign wr_ctrl   = reg_wr & (reg_addr == `EMDR_A_CTRL);
  assign wr_vrange = reg_wr & (reg_addr == `EMDR_A_VRANGE);
  assign wr_timer  = reg_wr & (reg_addr == `EMDR_A_TIMER);
  assign wr_minhit = reg_wr & (reg_addr == `EMDR_A_MINHIT);
  assign wr_policy = reg_wr & (reg_addr == `EMDR_A_POLICY);
  // writes to the read-only offsets match nothing here
  // the memory never reaches the control byte
  assign ee_timer  = cfg_ld & (cfg_addr == `EMDR_A_TIMER);
  assign ee_minhit = cfg_ld & (cfg_addr == `EMDR_A_MINHIT);
  assign ee_policy = cfg_ld & (cfg_addr == `EMDR_A_POLICY);

  // ----------------------------------------------------------
  // stored configuration bytes
  // ----------------------------------------------------------
  reg        rsvd_ctrl_q;    // reserved read/write bit 3
  reg [7:0]  vrange_rsvd_q;  // reserved read/write bits of eye_voltage_range_readback
  reg [7:0]  minhit_byte_q;  // full min_hit_count_config byte
  reg [7:0]  policy_byte_q;  // full adaptation_policy_config byte
  reg        scale_q;        // vertical opening scaling enable

  // control byte writable bits
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fast_mode_q <= 1'b0;
      rsvd_ctrl_q <= 1'b0;
    end else if (wr_ctrl) begin
      fast_mode_q <= reg_wdata[`EMDR_B_FAST];
      rsvd_ctrl_q <= reg_wdata[`EMDR_B_RSVD];
    end
  end

  // reserved bits around the range readback
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      vrange_rsvd_q <= `EMDR_R_ZERO;
    end else if (wr_vrange) begin
      // range bits are not stored here
      vrange_rsvd_q <= reg_wdata & 8'h9F;
    end
  end

  // timer threshold, bus write wins over memory load
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timer_threshold_q <= `EMDR_R_TIMER;
    end else if (wr_timer) begin
      timer_threshold_q <= reg_wdata;
    end else if (ee_timer) begin
      timer_threshold_q <= cfg_data;
    end
  end

  // minimum hit byte, top two bits not loadable
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      minhit_byte_q <= `EMDR_R_ZERO;
    end else if (wr_minhit) begin
      minhit_byte_q <= reg_wdata;
    end else if (ee_minhit) begin
      minhit_byte_q <= (minhit_byte_q & ~`EMDR_EE_MINHIT) |
                       (cfg_data & `EMDR_EE_MINHIT);
    end
  end

  // policy byte, bit 7 not loadable from memory
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      policy_byte_q <= `EMDR_R_POLICY;
    end else if (wr_policy) begin
      policy_byte_q <= reg_wdata;
    end else if (ee_policy) begin
      policy_byte_q <= (policy_byte_q & ~`EMDR_EE_POLICY) |
                       (cfg_data & `EMDR_EE_POLICY);
    end
  end

  // ----------------------------------------------------------
  // fields handed to the engines
  // ----------------------------------------------------------
  // byte defaults, so the copies match their bytes out of reset
  localparam [7:0] MINHIT_RST = `EMDR_R_ZERO;   // minimum hit byte default
  localparam [7:0] POLICY_RST = `EMDR_R_POLICY; // policy byte default

  // registered copies keep engine inputs glitch free
  // they trail their bytes by one cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      min_hits_q       <= MINHIT_RST[`EMDR_B_MIN_HI:`EMDR_B_MIN_LO];
      scale_q          <= POLICY_RST[`EMDR_B_SCALE];
      quality_metric_q <= POLICY_RST[`EMDR_B_QM_HI:`EMDR_B_QM_LO];
      look_beyond_q    <= POLICY_RST[`EMDR_B_LOOK_HI:`EMDR_B_LOOK_LO];
    end else begin
      min_hits_q       <= minhit_byte_q[`EMDR_B_MIN_HI:`EMDR_B_MIN_LO];
      scale_q          <= policy_byte_q[`EMDR_B_SCALE];
      quality_metric_q <= policy_byte_q[`EMDR_B_QM_HI:`EMDR_B_QM_LO];
      look_beyond_q    <= policy_byte_q[`EMDR_B_LOOK_HI:`EMDR_B_LOOK_LO];
    end
  end

  // ----------------------------------------------------------
  // self-clearing start bits
  // ----------------------------------------------------------
  wire       qm_valid;   // metric choice other than not-valid
  wire       qm_reject;  // adaptation asked with not-valid metric
  wire [2:0] launch;     // start requests per operation
  wire [2:0] done;       // completion per operation
  wire [2:0] busy;       // start bits as read back
  wire [2:0] go;         // launch pulses to the engines

  // metric is taken from the byte, so a write in the cycle before counts
  assign qm_valid  = policy_byte_q[`EMDR_B_QM_HI:`EMDR_B_QM_LO] !=
                     `EMDR_QM_NONE;
  assign qm_reject = wr_ctrl & reg_wdata[`EMDR_B_DFE_GO] & ~qm_valid &
                     ~busy[2];
  assign launch[0] = wr_ctrl & reg_wdata[`EMDR_B_CNT_GO];
  assign launch[1] = wr_ctrl & reg_wdata[`EMDR_B_EYE_GO];
  assign launch[2] = wr_ctrl & reg_wdata[`EMDR_B_DFE_GO] & qm_valid;
  assign done      = {adapt_done, opening_done, eye_monitor_done};

  // a zero written to a start bit leaves its operation alone
  // one tracker per start bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_op
      emdr_op u_op (
        .mclk   (mclk),
        .resetn (resetn),
        .launch (launch[gi]),
        .done   (done[gi]),
        .busy_q (busy[gi]),
        .go_q   (go[gi])
      );
    end
  endgenerate

  // launch pulses come straight from tracker flops
  assign eye_monitor_start = go[0];
  assign opening_start     = go[1];
  assign adapt_start       = go[2];

  // ----------------------------------------------------------
  // error flags
  // ----------------------------------------------------------
  reg no_lock_q;  // adaptation ended without lock
  reg no_hits_q;  // no hits at the crossing point
  reg no_vert_q;  // vertical eye not visible

  // completion wins over a start in the same cycle
  // adaptation flag: cleared by start, set by end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      no_lock_q <= 1'b0;
    end else if (busy[2] && adapt_done) begin
      no_lock_q <= ~adapt_locked;
    end else if (qm_reject) begin
      // refused start ends at once without lock
      no_lock_q <= 1'b1;
    end else if (launch[2] && !busy[2]) begin
      no_lock_q <= 1'b0;
    end
  end

  // measurement flags: cleared by start, set by end
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      no_hits_q <= 1'b0;
      no_vert_q <= 1'b0;
    end else if (busy[1] && opening_done) begin
      no_hits_q <= opening_no_hits;
      no_vert_q <= opening_no_vert;
    end else if (launch[1] && !busy[1]) begin
      no_hits_q <= 1'b0;
      no_vert_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // results captured on completion
  // ----------------------------------------------------------
  reg [15:0] count_q;  // eye monitor hit count
  reg [7:0]  hopen_q;  // horizontal opening
  reg [7:0]  vopen_q;  // vertical opening as reported
  reg [10:0] vshift;   // vertical opening shifted by range
  reg [7:0]  vscaled;  // vertical opening after scaling

  // the range in force at completion is the one applied
  // scaling: one doubling per range step, saturating
  always @* begin
    vshift  = {3'h0, vertical_eye_opening} << eye_monitor_vrange;
    vscaled = (|vshift[10:8]) ? `EMDR_SAT : vshift[7:0];
    if (!scale_q) begin
      vscaled = vertical_eye_opening;
    end
  end

  // a done while idle leaves the result alone
  // counter result
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 16'h0000;
    end else if (busy[0] && eye_monitor_done) begin
      count_q <= eye_monitor_count;
    end
  end

  // opening results, horizontal clamped to phase range
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hopen_q <= `EMDR_R_ZERO;
      vopen_q <= `EMDR_R_ZERO;
    end else if (busy[1] && opening_done) begin
      if (horizontal_eye_opening > `EMDR_HOPEN_MAX) begin
        hopen_q <= `EMDR_HOPEN_MAX;
      end else begin
        hopen_q <= horizontal_eye_opening;
      end
      vopen_q <= vscaled;
    end
  end

  // ----------------------------------------------------------
  // read data
  // ----------------------------------------------------------
  reg [7:0] rd_mux;  // selected byte

  // unmapped offsets read as zero
  always @* begin
    case (reg_addr)
      `EMDR_A_CTRL: begin
        rd_mux = {fast_mode_q, no_lock_q, no_hits_q, no_vert_q,
                  rsvd_ctrl_q, busy};
      end
      `EMDR_A_CNT_HI: begin
        rd_mux = count_q[15:8];
      end
      `EMDR_A_CNT_LO: begin
        rd_mux = count_q[7:0];
      end
      `EMDR_A_HOPEN: begin
        rd_mux = hopen_q;
      end
      `EMDR_A_VOPEN: begin
        rd_mux = vopen_q;
      end
      `EMDR_A_VRANGE: begin
        rd_mux = vrange_rsvd_q | {1'b0, eye_monitor_vrange, 5'h00};
      end
      `EMDR_A_TIMER: begin
        rd_mux = timer_threshold_q;
      end
      `EMDR_A_MINHIT: begin
        rd_mux = minhit_byte_q;
      end
      `EMDR_A_POLICY: begin
        rd_mux = policy_byte_q;
      end
      default: begin
        rd_mux = `EMDR_R_ZERO;
      end
    endcase
  end

  // a read in a write cycle returns the old byte
  // read data held until the next read
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= `EMDR_R_ZERO;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ==== tb/emdr_regs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker of the control slice
// ------------------------------------------------------------
module emdr_regs_props (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [1:0] eye_monitor_vrange,
  input wire logic       eye_monitor_start,
  input wire logic       opening_start,
  input wire logic       adapt_start,
  input wire logic       fast_mode_q,
  input wire logic [7:0] timer_threshold_q,
  input wire logic [3:0] min_hits_q
);
  // start bits written to the control byte this cycle
  wire [2:0] go_w = (reg_wr && reg_addr == 8'h24) ? reg_wdata[2:0] : 3'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_cnt_go_cause: assert property (
    eye_monitor_start |-> $past(go_w[0]) || $past(go_w[0], 2)) else $error("stray count start");
  chk_open_go_cause: assert property (
    opening_start |-> $past(go_w[1]) || $past(go_w[1], 2)) else $error("stray opening start");
  chk_adapt_go_cause: assert property (
    adapt_start |-> $past(go_w[2]) || $past(go_w[2], 2)) else $error("stray adapt start");
  chk_cnt_go_pulse: assert property (
    eye_monitor_start |=> !eye_monitor_start) else $error("count start too long");
  chk_open_go_pulse: assert property (
    opening_start |=> !opening_start) else $error("opening start too long");
  chk_adapt_go_pulse: assert property (
    adapt_start |=> !adapt_start) else $error("adapt start too long");
  chk_fast_mode_set: assert property (
    (reg_wr && reg_addr == 8'h24) |=> fast_mode_q == $past(reg_wdata[7])) else $error("fast mode");
  chk_timer_thr_load: assert property (
    (reg_wr && reg_addr == 8'h2A) |=> timer_threshold_q == $past(reg_wdata))
    else $error("timer threshold");
  chk_min_hits_out: assert property (
    (reg_wr && reg_addr == 8'h2B) |=> ##1 min_hits_q == $past(reg_wdata[3:0], 2))
    else $error("minimum hits");
  chk_vrange_echo: assert property (
    (reg_rd && reg_addr == 8'h29) |=> reg_rdata_q[6:5] == $past(eye_monitor_vrange))
    else $error("range echo");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata_q)) else $error("read data moved");
endmodule
bind emdr_regs emdr_regs_props emdr_regs_props_inst (.mclk, .resetn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata_q, .eye_monitor_vrange, .eye_monitor_start,
  .opening_start, .adapt_start, .fast_mode_q, .timer_threshold_q, .min_hits_q);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic        mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, cfg_ld = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, cfg_addr = 0, cfg_data = 0, h_open = 0, v_open = 0;
  logic [7:0]  reg_rdata_q, tmr;
  logic [1:0]  vr = 2'h2, qm;
  logic        ems, emd = 0, ops, opd = 0, ads, add = 0, nh = 0, nv = 0, lk = 0, fast;
  logic [15:0] cnt = 0;
  logic [3:0]  mh, lb;
  int          n_fail = 0, n_tests = 0, n_em = 0, n_op = 0, n_ad = 0, cyc = 0;
  always #25 mclk = ~mclk;
  emdr_regs emdr_regs_inst (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .cfg_ld(cfg_ld),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .eye_monitor_vrange(vr),
    .eye_monitor_start(ems), .eye_monitor_done(emd), .eye_monitor_count(cnt),
    .opening_start(ops), .opening_done(opd), .horizontal_eye_opening(h_open),
    .vertical_eye_opening(v_open), .opening_no_hits(nh), .opening_no_vert(nv),
    .adapt_start(ads), .adapt_done(add), .adapt_locked(lk), .fast_mode_q(fast),
    .timer_threshold_q(tmr), .min_hits_q(mh), .quality_metric_q(qm), .look_beyond_q(lb));
  // count start pulses mid-cycle where they stand, cut a hang short
  always @(negedge mclk) begin
    n_em += ems;
    n_op += ops;
    n_ad += ads;
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report;
    end
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge mclk) reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge mclk) reg_rd = 0;
    `CHK("read data", e, reg_rdata_q)
  endtask
  task automatic ld(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk) {cfg_ld, cfg_addr, cfg_data} = {1'b1, a, d};
    @(negedge mclk) cfg_ld = 0;
  endtask
  // one done pulse: 0 counter, 1 opening, 2 adaptation
  task automatic done(input int k);
    @(negedge mclk) {emd, opd, add} = {k == 0, k == 1, k == 2};
    @(negedge mclk) {emd, opd, add} = 3'h0;
  endtask
  task final_report;
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h30, 8'h00, 8'h72};
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1;
    for (int i = 0; i < 9; i++) rd(8'h24 + i[7:0], rv[i]);
    rd(8'h2D, 8'h00);
    wr(8'h24, 8'h88);
    rd(8'h24, 8'h88);
    `CHK("fast", 1'b1, fast)
    wr(8'h2A, 8'hA5);
    rd(8'h2A, 8'hA5);
    `CHK("timer", 8'hA5, tmr)
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'hFF);
    `CHK("min hits", 4'hF, mh)
    wr(8'h2C, 8'h15);
    rd(8'h2C, 8'h15);
    `CHK("metric", 2'h1, qm)
    `CHK("look", 4'h5, lb)
    wr(8'h25, 8'hFF);
    rd(8'h25, 8'h00);
    wr(8'h29, 8'hFF);
    rd(8'h29, 8'hDF);
    ld(8'h2A, 8'h5A);
    rd(8'h2A, 8'h5A);
    ld(8'h2B, 8'h05);
    rd(8'h2B, 8'hC5);
    ld(8'h24, 8'hFF);
    rd(8'h24, 8'h88);
    // counter run, repeated start while busy, done while idle
    wr(8'h24, 8'h01);
    rd(8'h24, 8'h01);
    wr(8'h24, 8'h01);
    cnt = 16'hBEEF;
    done(0);
    rd(8'h24, 8'h00);
    cnt = 16'h1234;
    done(0);
    rd(8'h25, 8'hBE);
    rd(8'h26, 8'hEF);
    `CHK("count starts", 1, n_em)
    // opening runs unscaled then scaled
    wr(8'h24, 8'h02);
    {h_open, v_open, nh} = {8'h50, 8'h21, 1'b1};
    done(1);
    rd(8'h24, 8'h20);
    rd(8'h27, 8'h3F);
    rd(8'h28, 8'h21);
    wr(8'h2C, 8'h72);
    wr(8'h24, 8'h02);
    rd(8'h24, 8'h02);
    {h_open, nh, nv} = {8'h10, 1'b0, 1'b1};
    done(1);
    rd(8'h24, 8'h10);
    rd(8'h27, 8'h10);
    rd(8'h28, 8'h84);
    `CHK("opening starts", 2, n_op)
    // adaptation without and with lock, then invalid metric
    wr(8'h24, 8'h04);
    rd(8'h24, 8'h14);
    done(2);
    rd(8'h24, 8'h50);
    wr(8'h24, 8'h04);
    rd(8'h24, 8'h14);
    lk = 1;
    done(2);
    rd(8'h24, 8'h10);
    wr(8'h2C, 8'h42);
    wr(8'h24, 8'h04);
    rd(8'h24, 8'h50);
    `CHK("adapt starts", 2, n_ad)
    // metric from vertical only, then a saturating scaled opening
    wr(8'h2C, 8'h62);
    rd(8'h2C, 8'h62);
    `CHK("metric", 2'h2, qm)
    {h_open, v_open} = {8'h3F, 8'h50};
    wr(8'h24, 8'h02);
    done(1);
    rd(8'h24, 8'h50);
    rd(8'h27, 8'h3F);
    rd(8'h28, 8'hFF);
    `CHK("opening starts", 3, n_op)
    // reset with all runs finished brings back the defaults
    @(negedge mclk) resetn = 0;
    @(negedge mclk) resetn = 1;
    rd(8'h24, 8'h00);
    rd(8'h25, 8'h00);
    rd(8'h2C, 8'h72);
    `CHK("look", 4'h2, lb)
    final_report;
  end
endmodule
`default_nettype wire
